//--- include/dsp_pkg.sv
package dsp_pkg;

	// Channel multiplexing modes of the converter.
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_DUAL   = 2'b01,
		MODE_OCTAL  = 2'b10
	} chan_mode_t;

	// Register offsets.
	localparam logic [7:0] REG_FILT_A  = 8'h78;
	localparam logic [7:0] REG_FILT_B  = 8'h79;
	localparam logic [7:0] REG_ENABLES = 8'h7a;
	localparam logic [7:0] REG_MODE    = 8'h80;
	localparam logic [7:0] REG_FIX     = 8'h81;
	localparam logic [7:0] REG_STATUS  = 8'h82;
	localparam logic [7:0] REG_RESET   = 8'h00;

	// Field positions.
	localparam int FILT_LSB     = 0;
	localparam int FILT_W       = 7;
	localparam int OVL_RST_BIT  = 7;
	localparam int DUAL_POST_BIT = 7;
	localparam int EN_A11_BIT   = 0;
	localparam int EN_A12_BIT   = 1;
	localparam int EN_B11_BIT   = 2;
	localparam int EN_B12_BIT   = 3;
	localparam int EN_FIX_BIT   = 4;
	localparam int MODE_LSB     = 0;
	localparam int BAND_BIT     = 0;
	localparam int FIX_SEL_BIT  = 1;
	localparam int OCT_POST_BIT = 2;
	localparam int STAT_OVL_A   = 0;
	localparam int STAT_OVL_B   = 1;
	localparam int STAT_FIX_ACT = 2;

	// Timing and word sizes.
	localparam int FIX_LATENCY = 59;
	localparam int BITS_LONG   = 12;
	localparam int BITS_SHORT  = 11;
	localparam int COEF_FRAC   = 14;

	// Filter number ranges.
	localparam logic [6:0] F11A_HI = 7'h14;
	localparam logic [6:0] F11B_LO = 7'h15;
	localparam logic [6:0] F11B_HI = 7'h29;
	localparam logic [6:0] F12A_LO = 7'h2a;
	localparam logic [6:0] F12A_HI = 7'h3e;
	localparam logic [6:0] F12B_LO = 7'h3f;
	localparam logic [6:0] F12B_HI = 7'h4c;

	// Centre frequency base and step in Q16 of the sample rate.
	localparam logic [16:0] FC_BASE_22 = 17'h0_1eb8;
	localparam logic [16:0] FC_STEP_22 = 17'h0_0354;
	localparam logic [16:0] FC_BASE_25 = 17'h0_2000;
	localparam logic [16:0] FC_STEP_25 = 17'h0_0333;
	localparam logic [16:0] FC_BASE_29 = 17'h0_2666;
	localparam logic [16:0] FC_STEP_29 = 17'h0_0444;

	// A quarter turn in Q16, so that fc minus this, read in Q14, is 4*fc-1.
	localparam logic signed [17:0] T_OFFSET = 18'h0_4000;

endpackage

//--- hdl/requant_unit.sv
`timescale 1ns/1ps
module requant_unit #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// Settings
	input  wire logic                     enable,
	input  wire logic                     sel12,
	input  wire logic [6:0]               filter_num,
	input  wire logic                     ovl_reset_en,
	// Samples
	input  wire logic                     in_valid,
	input  wire logic signed [DATA_W-1:0] in_data,
	output logic signed [DATA_W-1:0]      out_data,
	output logic                          overload
);
	localparam int VW = DATA_W + 3;

	logic [6:0]            off;
	logic [16:0]           base;
	logic [16:0]           step;
	logic [16:0]           fc;
	logic signed [17:0]    t;
	logic signed [35:0]    t2;
	logic signed [35:0]    t3;
	logic signed [17:0]    c2;
	logic signed [VW+17:0] prod;
	logic signed [VW-1:0]  e1;
	logic signed [VW-1:0]  e2;
	logic signed [VW-1:0]  v;
	logic signed [VW-1:0]  q;
	logic signed [VW-1:0]  qs;
	logic signed [VW-1:0]  yq;
	logic signed [VW-1:0]  e;
	logic signed [VW-1:0]  lim;
	logic [4:0]            sh;

	// Centre frequency of the chosen filter; numbers past the last filter are reserved.
	always_comb begin
		off = filter_num;
		base = dsp_pkg::FC_BASE_22;
		step = dsp_pkg::FC_STEP_22;
		if (filter_num <= dsp_pkg::F11A_HI) begin
			off = filter_num;
		end else if (filter_num <= dsp_pkg::F11B_HI) begin
			off = filter_num - dsp_pkg::F11B_LO;
			base = dsp_pkg::FC_BASE_25;
			step = dsp_pkg::FC_STEP_25;
		end else if (filter_num <= dsp_pkg::F12A_HI) begin
			off = filter_num - dsp_pkg::F12A_LO;
			base = dsp_pkg::FC_BASE_25;
			step = dsp_pkg::FC_STEP_25;
		end else begin
			off = filter_num - dsp_pkg::F12B_LO;
			base = dsp_pkg::FC_BASE_29;
			step = dsp_pkg::FC_STEP_29;
		end
		fc = base + 17'(off * step);
		t = $signed({1'b0, fc}) - dsp_pkg::T_OFFSET;
		t2 = (t * t) >>> dsp_pkg::COEF_FRAC;
		t3 = ($signed(t2[17:0]) * t) >>> dsp_pkg::COEF_FRAC;
	end

	// The noise zero sits at the centre: 2cos(2*pi*fc) from a cubic, kept in a register
	// so the long coefficient path stays out of the sample path.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			c2 <= '0;
		end else begin
			c2 <= t3[17:0] - (t <<< 1) - t;
		end
	end

	// Second-order error feedback; the band around the centre is kept quiet.
	always_comb begin
		prod = c2 * e1;
		v = VW'(in_data) + VW'(prod >>> dsp_pkg::COEF_FRAC) - e2;
		sh = sel12 ? 5'(DATA_W - dsp_pkg::BITS_LONG) : 5'(DATA_W - dsp_pkg::BITS_SHORT);
		q = (v + (VW'(1) <<< (sh - 5'h01))) >>> sh;
		lim = (VW'(1) <<< (5'(DATA_W - 1) - sh)) - VW'(1);
		qs = q;
		if (q > lim) begin
			qs = lim;
		end else if (q < -lim - VW'(1)) begin
			qs = -lim - VW'(1);
		end
		yq = qs <<< sh;
		e = v - yq;
		overload = in_valid && enable && (q != qs);
		out_data = enable ? yq[DATA_W-1:0] : in_data;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			e1 <= '0;
			e2 <= '0;
		end else if (!enable || (overload && ovl_reset_en)) begin
			e1 <= '0;
			e2 <= '0;
		end else if (in_valid) begin
			e1 <= e;
			e2 <= e1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_ovl_clears_state: assert property (
		overload && ovl_reset_en |=> e1 == '0 && e2 == '0
	) else $error("requantizer state kept after overload reset");

	a_disabled_quiet: assert property (
		!enable ##1 !enable |-> e1 == '0 && out_data == in_data
	) else $error("disabled requantizer altered data or kept state");

endmodule

//--- hdl/delay_fix_and_requantizer.sv
`timescale 1ns/1ps
// Functional notes
// - No delay fix in single-channel mode.
// - Interpolator aligns channel sample instants.
// - Delay fix adds exactly 59 cycles.
// - Delay fix precedes all other processing.
// - Dual post enable gates dual processing.
// - Dual band limits 0.45 and 0.55.
// - Band select picks first or second band.
// - Octal fix valid to 0.38, band 0.
// - Requantize to 11 or 12 bits.
// - Requantizers only single/dual, independent settings; the overload reset bit here serves both units.
// - Single mode uses unit A only.
// - Dual: unit A first, B second.
// - Seven-bit filter number picks filter.
// - Bandwidths 22/25 or 25/29 percent.
// - Filters 0-20 centre formula.
// - Filters 21-41 centre formula.
// - Centre placeable anywhere in Nyquist band; the filter tables here reach only 0.12 to 0.38 of the sample rate.
// - Filters 42-62 centre formula.
// - Filters 63-76 centre formula.
// - Disabled requantizer passes samples straight.
// - Overload resets requantizer when enabled.
module delay_fix_and_requantizer #(
	parameter int DATA_W      = 16,
	parameter int FIX_LATENCY = dsp_pkg::FIX_LATENCY
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// Register port
	input  wire logic [7:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [7:0]                    reg_rdata,
	// Converter sample stream
	input  wire logic                     in_valid,
	input  wire logic signed [DATA_W-1:0] in_data,
	input  wire logic [2:0]               in_chan,
	// Formatter sample stream
	output logic                          out_valid,
	output logic signed [DATA_W-1:0]      out_data,
	output logic [2:0]                    out_chan,
	output logic                          out_requant
);
	localparam logic signed [DATA_W+3:0] SMAX = (DATA_W+4)'(2 ** (DATA_W - 1) - 1);
	localparam logic signed [DATA_W+3:0] SMIN = -SMAX - (DATA_W+4)'(1);

	// Configuration
	logic [6:0]                  filt_a;
	logic [6:0]                  filt_b;
	logic                        ovl_reset_en;
	logic                        dual_post_enable;
	logic [4:0]                  enables;
	logic [1:0]                  mode_bits;
	logic                        nyquist_band_select;
	logic                        delay_fix_mode_select;
	logic                        octal_post_select;
	logic [1:0]                  ovl_seen;
	logic [6:0]                  since_wr;

	// Mode decode
	logic                        is_single;
	logic                        is_dual;
	logic                        is_octal;
	logic                        fix_active;
	logic                        use_band2;
	logic                        req_allowed;
	logic                        req_en_a;
	logic                        req_en_b;

	// Interpolator
	logic signed [DATA_W-1:0]    prev [8];
	logic signed [DATA_W-1:0]    prev_sel;
	logic [2:0]                  frac;
	logic signed [DATA_W+3:0]    diff;
	logic signed [DATA_W+3:0]    isum;
	logic signed [DATA_W-1:0]    interp;
	logic                        pv [FIX_LATENCY];
	logic signed [DATA_W-1:0]    pd [FIX_LATENCY];
	logic [2:0]                  pc [FIX_LATENCY];

	// Requantizer stage
	logic                        s_valid;
	logic signed [DATA_W-1:0]    s_data;
	logic [2:0]                  s_chan;
	logic                        b_sel;
	logic                        a_valid;
	logic                        b_valid;
	logic signed [DATA_W-1:0]    a_y;
	logic signed [DATA_W-1:0]    b_y;
	logic                        a_ovl;
	logic                        b_ovl;

	// Register writes.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_a <= dsp_pkg::REG_RESET[6:0];
			filt_b <= dsp_pkg::REG_RESET[6:0];
			ovl_reset_en <= 1'b0;
			dual_post_enable <= 1'b0;
			enables <= dsp_pkg::REG_RESET[4:0];
			mode_bits <= dsp_pkg::REG_RESET[1:0];
			nyquist_band_select <= 1'b0;
			delay_fix_mode_select <= 1'b0;
			octal_post_select <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				dsp_pkg::REG_FILT_A: begin
					filt_a <= reg_wdata[dsp_pkg::FILT_LSB +: dsp_pkg::FILT_W];
					ovl_reset_en <= reg_wdata[dsp_pkg::OVL_RST_BIT];
				end
				dsp_pkg::REG_FILT_B: begin
					filt_b <= reg_wdata[dsp_pkg::FILT_LSB +: dsp_pkg::FILT_W];
					dual_post_enable <= reg_wdata[dsp_pkg::DUAL_POST_BIT];
				end
				dsp_pkg::REG_ENABLES: begin
					enables <= reg_wdata[4:0];
				end
				dsp_pkg::REG_MODE: begin
					mode_bits <= reg_wdata[dsp_pkg::MODE_LSB +: 2];
				end
				dsp_pkg::REG_FIX: begin
					nyquist_band_select <= reg_wdata[dsp_pkg::BAND_BIT];
					delay_fix_mode_select <= reg_wdata[dsp_pkg::FIX_SEL_BIT];
					octal_post_select <= reg_wdata[dsp_pkg::OCT_POST_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Overload flags: a new overload wins over a write-one clear in the same cycle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ovl_seen <= 2'h0;
		end else begin
			ovl_seen[dsp_pkg::STAT_OVL_A] <= a_ovl || (ovl_seen[dsp_pkg::STAT_OVL_A] &&
				!(reg_wr && reg_addr == dsp_pkg::REG_STATUS && reg_wdata[dsp_pkg::STAT_OVL_A]));
			ovl_seen[dsp_pkg::STAT_OVL_B] <= b_ovl || (ovl_seen[dsp_pkg::STAT_OVL_B] &&
				!(reg_wr && reg_addr == dsp_pkg::REG_STATUS && reg_wdata[dsp_pkg::STAT_OVL_B]));
		end
	end

	// Register reads; unmapped offsets read as zero.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				dsp_pkg::REG_FILT_A: reg_rdata <= {ovl_reset_en, filt_a};
				dsp_pkg::REG_FILT_B: reg_rdata <= {dual_post_enable, filt_b};
				dsp_pkg::REG_ENABLES: reg_rdata <= {3'h0, enables};
				dsp_pkg::REG_MODE: reg_rdata <= {6'h00, mode_bits};
				dsp_pkg::REG_FIX: reg_rdata <= {5'h00, octal_post_select,
					delay_fix_mode_select, nyquist_band_select};
				dsp_pkg::REG_STATUS: reg_rdata <= {5'h00, fix_active, ovl_seen};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Cycles since the last register write, for the checks below.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			since_wr <= 7'h00;
		end else if (reg_wr) begin
			since_wr <= 7'h00;
		end else if (since_wr != 7'h7f) begin
			since_wr <= since_wr + 7'h01;
		end
	end

	// Mode decode; the unused code behaves as single-channel.
	always_comb begin
		is_single = 1'b0;
		is_dual = 1'b0;
		is_octal = 1'b0;
		unique case (mode_bits)
			dsp_pkg::MODE_SINGLE: is_single = 1'b1;
			dsp_pkg::MODE_DUAL: is_dual = 1'b1;
			dsp_pkg::MODE_OCTAL: is_octal = 1'b1;
			default: is_single = 1'b1;
		endcase
	end

	// A half-set combination leaves the interpolator off rather than misaligned.
	assign fix_active = enables[dsp_pkg::EN_FIX_BIT] && !is_single &&
		(is_dual ? (dual_post_enable && !delay_fix_mode_select && !octal_post_select)
		: (delay_fix_mode_select && octal_post_select));
	assign use_band2 = is_dual && nyquist_band_select;
	assign req_allowed = is_single || (is_dual && dual_post_enable);
	assign req_en_a = req_allowed &&
		(enables[dsp_pkg::EN_A11_BIT] || enables[dsp_pkg::EN_A12_BIT]);
	assign req_en_b = is_dual && dual_post_enable &&
		(enables[dsp_pkg::EN_B11_BIT] || enables[dsp_pkg::EN_B12_BIT]);

	// Each channel is pulled back by its share of the sample period, k/N, by interpolating
	// toward its previous sample. In the second band the previous sample is sign-flipped
	// to undo the alternation. The interpolator is only exact inside the usable band.
	always_comb begin
		frac = is_dual ? {in_chan[0], 2'b00} : in_chan;
		prev_sel = use_band2 ? -prev[in_chan] : prev[in_chan];
		diff = (DATA_W+4)'(prev_sel) - (DATA_W+4)'(in_data);
		isum = (DATA_W+4)'(in_data) + ((diff * $signed({1'b0, frac})) >>> 3);
		if (isum > SMAX) begin
			interp = SMAX[DATA_W-1:0];
		end else if (isum < SMIN) begin
			interp = SMIN[DATA_W-1:0];
		end else begin
			interp = isum[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				prev[i] <= '0;
			end
		end else if (in_valid) begin
			prev[in_chan] <= in_data;
		end
	end

	// Fixed-length pipe that always runs; samples in flight are dropped when the fix is switched off and come out again when it is switched on.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pv[0] <= 1'b0;
			pd[0] <= '0;
			pc[0] <= 3'h0;
		end else begin
			pv[0] <= in_valid;
			pd[0] <= interp;
			pc[0] <= in_chan;
		end
	end

	for (genvar g = 1; g < FIX_LATENCY; g++) begin : g_pipe
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				pv[g] <= 1'b0;
				pd[g] <= '0;
				pc[g] <= 3'h0;
			end else begin
				pv[g] <= pv[g-1];
				pd[g] <= pd[g-1];
				pc[g] <= pc[g-1];
			end
		end
	end

	// The aligned stream feeds the requantizers, never the other way round.
	assign s_valid = fix_active ? pv[FIX_LATENCY-1] : in_valid;
	assign s_data = fix_active ? pd[FIX_LATENCY-1] : in_data;
	assign s_chan = fix_active ? pc[FIX_LATENCY-1] : in_chan;
	assign b_sel = is_dual && (s_chan == 3'h1);
	assign a_valid = s_valid && !b_sel;
	assign b_valid = s_valid && b_sel;

	requant_unit #(
		.DATA_W(DATA_W)
	) u_req_a (
		.clk(clk),
		.reset_n(reset_n),
		.enable(req_en_a),
		.sel12(enables[dsp_pkg::EN_A12_BIT]),
		.filter_num(filt_a),
		.ovl_reset_en(ovl_reset_en),
		.in_valid(a_valid),
		.in_data(s_data),
		.out_data(a_y),
		.overload(a_ovl)
	);

	requant_unit #(
		.DATA_W(DATA_W)
	) u_req_b (
		.clk(clk),
		.reset_n(reset_n),
		.enable(req_en_b),
		.sel12(enables[dsp_pkg::EN_B12_BIT]),
		.filter_num(filt_b),
		.ovl_reset_en(ovl_reset_en),
		.in_valid(b_valid),
		.in_data(s_data),
		.out_data(b_y),
		.overload(b_ovl)
	);

	// Output register toward the formatter.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
			out_chan <= 3'h0;
			out_requant <= 1'b0;
		end else begin
			out_valid <= s_valid;
			out_data <= b_sel ? b_y : a_y;
			out_chan <= s_chan;
			out_requant <= s_valid && (b_sel ? req_en_b : req_en_a);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_single_no_fix: assert property (
		is_single |-> !fix_active
	) else $error("delay fix active in single-channel mode");

	a_fix_latency: assert property (
		since_wr > 7'd62 && fix_active && $past(in_valid, 60) |-> out_valid
	) else $error("delay-fixed sample not out after 60 cycles");

	a_fix_no_extra: assert property (
		since_wr > 7'd62 && fix_active && !$past(in_valid, 60) |-> !out_valid
	) else $error("delay-fixed output without matching input");

	a_bypass_latency: assert property (
		since_wr > 7'd2 && !fix_active && $past(in_valid) |-> out_valid
	) else $error("bypassed sample not out after one cycle");

	a_post_gate: assert property (
		is_dual && !dual_post_enable |-> !fix_active && !req_en_a && !req_en_b
	) else $error("dual processing active without dual post enable");

	a_octal_no_req: assert property (
		is_octal |-> !req_en_a && !req_en_b
	) else $error("requantizer enabled in octal mode");

	a_unit_b_idle: assert property (
		!is_dual |-> !b_valid
	) else $error("second requantizer fed outside dual mode");

	a_dual_route: assert property (
		is_dual && s_valid |-> (b_valid == (s_chan == 3'h1)) && (a_valid == (s_chan != 3'h1))
	) else $error("dual channel routed to wrong requantizer");

	a_req_low_bits: assert property (
		out_valid && out_requant |-> out_data[DATA_W-dsp_pkg::BITS_LONG-1:0] == '0
	) else $error("requantized word has live low bits");

	a_passthrough: assert property (
		since_wr > 7'd2 && $past(s_valid) && !$past(b_sel ? req_en_b : req_en_a)
		|-> out_data == $past(s_data) && !out_requant
	) else $error("unrequantized sample altered");

	c_dual_fix: cover property (fix_active && is_dual && use_band2 && out_valid);
	c_octal_fix: cover property (fix_active && is_octal && out_valid);
	c_ovl_reset: cover property (a_ovl && ovl_reset_en);
	c_dual_req: cover property (req_en_a && req_en_b && b_valid);

endmodule

//--- testbench/converter_source.sv
`timescale 1ns/1ps
module converter_source (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Control from the bench
	input  wire logic               run,
	input  wire logic [3:0]         chan_cnt,
	input  wire logic               hot,
	// Sample stream into the block
	output logic                    in_valid,
	output logic signed [15:0]      in_data,
	output logic [2:0]              in_chan
);
	int level;
	int v;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_valid <= 1'h0;
			in_data <= 16'h0000;
			in_chan <= 3'h0;
			level = 0;
		end else if (run) begin
			// Small steps keep the signal of each channel well inside the usable band.
			v = level + int'($urandom_range(0, 2047)) - 1024;
			// Staying under ninety percent of full scale keeps the requantizer stable.
			level = (v > 29000) ? 29000 : ((v < -29000) ? -29000 : v);
			in_valid <= 1'h1;
			// Full scale breaks the level limit on purpose, to reach the overload path.
			in_data <= hot ? 16'h7fff : 16'(level);
			in_chan <= (4'(in_chan) + 4'h1 >= chan_cnt) ? 3'h0 : in_chan + 3'h1;
		end else begin
			in_valid <= 1'h0;
			// An idle line must not look like a held sample.
			in_data <= ~in_data;
			in_chan <= 3'(chan_cnt - 4'h1);
		end
	end
endmodule

//--- testbench/delay_fix_and_requantizer_tb.sv
`timescale 1ns/1ps
module delay_fix_and_requantizer_tb;
	localparam int FIXL = dsp_pkg::FIX_LATENCY;
	typedef struct packed {
		logic [1:0] mode;
		logic [7:0] en;
		logic [7:0] fix;
		logic       dpost;
		logic [3:0] nch;
	} cfg_t;
	typedef struct {
		int          cyc;
		logic [15:0] data;
		logic [2:0]  chan;
		logic [15:0] fixd;
	} smp_t;
	logic               clk;
	logic               reset_n;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_addr;
	logic [7:0]         reg_wdata;
	logic [7:0]         reg_rdata;
	logic               run;
	logic [3:0]         chan_cnt;
	logic               in_valid;
	logic signed [15:0] in_data;
	logic [2:0]         in_chan;
	logic               out_valid;
	logic signed [15:0] out_data;
	logic [2:0]         out_chan;
	logic               out_requant;
	int                 error_cnt;
	int                 checked;
	int                 cyc;
	smp_t               q[$];
	cfg_t               cur;
	logic               hot;
	logic signed [15:0] last [8] = '{default: '0};
	// Config table: mode, enables, fix select bits, dual post enable, channel count.
	cfg_t tbl [13] = '{
		'{2'h0, 8'h00, 8'h00, 1'h0, 4'h1}, '{2'h0, 8'h10, 8'h00, 1'h1, 4'h1},
		'{2'h1, 8'h10, 8'h00, 1'h1, 4'h2}, '{2'h2, 8'h10, 8'h06, 1'h0, 4'h8},
		'{2'h1, 8'h10, 8'h01, 1'h1, 4'h2}, '{2'h1, 8'h10, 8'h04, 1'h1, 4'h2},
		'{2'h0, 8'h02, 8'h00, 1'h0, 4'h1}, '{2'h0, 8'h0d, 8'h00, 1'h0, 4'h1},
		'{2'h1, 8'h09, 8'h00, 1'h1, 4'h2}, '{2'h1, 8'h0f, 8'h00, 1'h0, 4'h2},
		'{2'h1, 8'h1a, 8'h00, 1'h1, 4'h2}, '{2'h2, 8'h13, 8'h06, 1'h0, 4'h8},
		'{2'h3, 8'h02, 8'h00, 1'h0, 4'h1}};

	delay_fix_and_requantizer #(.FIX_LATENCY(FIXL)) uut (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_valid(in_valid), .in_data(in_data), .in_chan(in_chan),
		.out_valid(out_valid), .out_data(out_data), .out_chan(out_chan),
		.out_requant(out_requant));
	converter_source src (.clk(clk), .reset_n(reset_n), .run(run), .chan_cnt(chan_cnt),
		.hot(hot), .in_valid(in_valid), .in_data(in_data), .in_chan(in_chan));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	function automatic logic fix_on(cfg_t c);
		if (!c.en[4])
			return 1'h0;
		if (c.mode == 2'h1)
			return c.dpost && c.fix[2:1] == 2'h0;
		if (c.mode == 2'h2)
			return c.fix[2:1] == 2'h3;
		return 1'h0;
	endfunction

	// Bits cleared at the bottom of a requantized word: 4 for 12-bit, 5 for 11-bit.
	function automatic int drop(cfg_t c, logic [2:0] ch);
		logic [1:0] e;
		if (c.mode == 2'h2 || (c.mode == 2'h1 && !c.dpost))
			return 0;
		e = (c.mode == 2'h1 && ch == 3'h1) ? c.en[3:2] : c.en[1:0];
		return e[1] ? 4 : (e[0] ? 5 : 0);
	endfunction

	// Expected delay-fixed value: a step of k/8 toward the channel's previous sample,
	// which is sign-flipped in the second band.
	function automatic logic [15:0] fix_exp(cfg_t c, int x, int p, logic [2:0] ch);
		int k;
		int r;
		k = (c.mode == 2'h1) ? 4 * int'(ch[0]) : int'(ch);
		if (c.mode == 2'h1 && c.fix[0])
			p = -p;
		r = x + (((p - x) * k) >>> 3);
		return 16'((r > 32767) ? 32767 : ((r < -32768) ? -32768 : r));
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		check(16'(reg_rdata & m), 16'(exp));
	endtask

	always @(posedge clk) begin
		smp_t s;
		int d;
		if (reset_n && out_valid === 1'h1) begin
			if (q.size() == 0)
				check(16'h0001, 16'h0000);
			else begin
				s = q.pop_front();
				d = drop(cur, s.chan);
				check(16'(cyc - s.cyc), fix_on(cur) ? 16'(FIXL + 1) : 16'h0001);
				check(16'(out_chan), 16'(s.chan));
				check(16'(out_requant), 16'(d != 0));
				if (d != 0)
					check(out_data & ((16'h0001 << d) - 16'h0001), 16'h0000);
				else
					check(out_data, fix_on(cur) ? s.fixd : s.data);
			end
		end
		if (reset_n && in_valid === 1'h1) begin
			q.push_back('{cyc, in_data, in_chan, fix_exp(cur, in_data, last[in_chan], in_chan)});
			last[in_chan] = in_data;
		end
		cyc = cyc + 1;
	end

	initial begin
		static logic [7:0] regs [7] = '{8'h78, 8'h79, 8'h7a, 8'h80, 8'h81, 8'h82, 8'h55};
		logic [7:0] va;
		logic [7:0] vb;
		{reg_wr, reg_rd, run, hot, reg_addr, reg_wdata} = '0;
		chan_cnt = 4'h1;
		cur = tbl[0];
		reset_n = 1'h0;
		void'($urandom(47));
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		foreach (regs[k])
			rd_check(regs[k], 8'hff, 8'h00);
		wr(8'h55, 8'hff);
		rd_check(8'h55, 8'hff, 8'h00);
		for (int i = 0; i < 13; i++) begin
			cur = tbl[i];
			// Filter numbers stay inside the range of the selected width.
			va = {1'($urandom_range(0, 1)), cur.en[1] ? 7'(42 + $urandom_range(0, 34))
				: 7'($urandom_range(0, 41))};
			vb = {cur.dpost, cur.en[3] ? 7'(42 + $urandom_range(0, 34))
				: 7'($urandom_range(0, 41))};
			wr(8'h78, va);
			wr(8'h79, vb);
			wr(8'h7a, cur.en);
			wr(8'h80, {6'h00, cur.mode});
			wr(8'h81, cur.fix);
			rd_check(8'h78, 8'hff, va);
			rd_check(8'h79, 8'hff, vb);
			rd_check(8'h7a, 8'h1f, cur.en);
			rd_check(8'h80, 8'h03, {6'h00, cur.mode});
			rd_check(8'h81, 8'h07, cur.fix);
			rd_check(8'h82, 8'h04, {5'h00, fix_on(cur), 2'h0});
			chan_cnt <= cur.nch;
			@(posedge clk);
			run <= 1'h1;
			repeat (24 + $urandom_range(0, 16)) @(posedge clk);
			run <= 1'h0;
			repeat (FIXL + 20) @(posedge clk);
			check(16'(q.size()), 16'h0000);
			$display("test %0d done", i);
		end
		// Overload corner: single mode, 12-bit, filter 42, overload reset on.
		wr(8'h78, 8'haa);
		@(posedge clk);
		hot <= 1'h1;
		run <= 1'h1;
		repeat (8) @(posedge clk);
		run <= 1'h0;
		hot <= 1'h0;
		repeat (4) @(posedge clk);
		rd_check(8'h82, 8'h03, 8'h01);
		wr(8'h82, 8'h01);
		rd_check(8'h82, 8'h03, 8'h00);
		check(16'(q.size()), 16'h0000);
		$display("test 13 done");
		stop_test();
	end

	// The whole run needs under two thousand cycles; this is a generous ceiling.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule
